// ==== design/gtg_pkg.sv ====
// constants and types shared by the general timer group
package gtg_pkg;
  // register byte addresses
  localparam logic [11:0] GTG_TMR1_ADDR = 12'h100;
  localparam logic [11:0] GTG_PR1_ADDR = 12'h102;
  localparam logic [11:0] GTG_T1_CTRL_ADDR = 12'h104;
  localparam logic [11:0] GTG_TMR2_ADDR = 12'h106;
  localparam logic [11:0] GTG_PR2_ADDR = 12'h108;
  localparam logic [11:0] GTG_T2_CTRL_ADDR = 12'h10A;
  localparam logic [11:0] GTG_TMR3_ADDR = 12'h10C;
  localparam logic [11:0] GTG_T3_GATE_ADDR = 12'h10E;
  localparam logic [11:0] GTG_T3_CTRL_ADDR = 12'h110;
  localparam logic [11:0] GTG_IRQ_STAT_ADDR = 12'h120;
  localparam logic [11:0] GTG_IRQ_EN_ADDR = 12'h124;
  localparam logic [11:0] GTG_IRQ_CLR_ADDR = 12'h128;
  // reset values
  localparam logic [15:0] GTG_PR1_RST = 16'hFFFF;
  localparam logic [15:0] GTG_PR2_RST = 16'h00FF;
  // timer one control fields
  localparam int GTG_T1_RUN_BIT = 15;
  localparam int GTG_T1_IDLE_BIT = 13;
  localparam int GTG_T1_ECS_LSB = 8;
  localparam int GTG_T1_GATE_BIT = 6;
  localparam int GTG_T1_PS_LSB = 4;
  localparam int GTG_T1_SYNC_BIT = 2;
  localparam int GTG_T1_SRC_BIT = 1;
  localparam logic [15:0] GTG_T1_MASK = 16'hA376;
  // timer two control fields
  localparam int GTG_T2_POST_LSB = 3;
  localparam int GTG_T2_RUN_BIT = 2;
  localparam logic [15:0] GTG_T2_MASK = 16'h007F;
  // timer three control and gate fields
  localparam int GTG_T3_CS_LSB = 6;
  localparam int GTG_T3_PS_LSB = 4;
  localparam int GTG_T3_RUN_BIT = 0;
  localparam logic [15:0] GTG_T3_MASK = 16'h00FD;
  localparam int GTG_G_EN_BIT = 7;
  localparam int GTG_G_POL_BIT = 6;
  localparam int GTG_G_TOG_BIT = 5;
  localparam int GTG_G_SPM_BIT = 4;
  localparam int GTG_G_GO_BIT = 3;
  localparam int GTG_G_VAL_BIT = 2;
  localparam logic [15:0] GTG_G_WMASK = 16'h00FB;
  // interrupt status bits
  localparam int GTG_IRQ_T1 = 0;
  localparam int GTG_IRQ_T2 = 1;
  localparam int GTG_IRQ_T3 = 2;
  localparam int GTG_IRQ_GATE = 3;
  // timer one extended clock codes
  typedef enum logic [1:0] {
    GTG_ECS_SECONDARY_OSC = 2'b00,
    GTG_ECS_EXT = 2'b01,
    GTG_ECS_LOW_POWER_RC_OSC = 2'b10,
    GTG_ECS_RSVD = 2'b11
  } gtg_ecs_t;
endpackage : gtg_pkg

// ==== design/gtg_timer_group.sv ====
// three general purpose timers (one and three 16-bit, two 8-bit) behind an apb slave
`timescale 1ns/1ns
// Notes on behaviour
// - ext select 10 rc osc, 01 ext clock, 00 secondary osc, 11 reserved
// - timer one prescale 256, 64, 8 or 1 by code 11..00
// - timer three runs as timer on internal clock or event counter
// - timer three count register is readable, and writable while the special event trigger is low
// - timer three clock from device clock, secondary or rc osc, or pin
// - timer three gate with software chosen source and polarity
// - gate toggle mode and single pulse one-shot mode
// - special event trigger resets timer three count
module gtg_timer_group
  import gtg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic device_idle,
  input wire logic secondary_osc_tick,
  input wire logic low_power_rc_osc_tick,
  input wire logic ext_clock_tick,
  input wire logic t3_ext_tick,
  input wire logic [3:0] gate_src,
  input wire logic special_event_trigger,
  output logic t2_match_out,
  output logic irq
);
  logic [15:0] tmr1_ff, pr1_ff, t1c_ff, tmr2_ff, pr2_ff, t2c_ff;
  logic [15:0] tmr3_ff, t3g_ff, t3c_ff;
  logic [7:0] ps1_ff, ps3_ff;
  logic [3:0] ps2_ff, post2_ff;
  logic [3:0] sts_ff, en_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, t2o_ff, irq_ff, gate_d_ff;
  logic [15:0] nxt_tmr1, nxt_pr1, nxt_t1c, nxt_tmr2, nxt_pr2, nxt_t2c;
  logic [15:0] nxt_tmr3, nxt_t3g, nxt_t3c;
  logic [7:0] nxt_ps1, nxt_ps3;
  logic [3:0] nxt_ps2, nxt_post2, nxt_sts, nxt_en;
  logic [31:0] nxt_prdata;
  logic nxt_pready, nxt_pslverr, nxt_t2o, nxt_irq, nxt_gate_d;

  // prescaler terminal count for a two-bit 1/8/64/256 code
  function automatic logic [7:0] gtg_div8(input logic [1:0] code);
    case (code)
      2'b11: gtg_div8 = 8'hFF;
      2'b10: gtg_div8 = 8'h3F;
      2'b01: gtg_div8 = 8'h07;
      default: gtg_div8 = 8'h00;
    endcase
  endfunction : gtg_div8

  // true for every byte address that a write reaches without an error
  function automatic logic gtg_mapped(input logic [11:0] addr);
    gtg_mapped = (addr == GTG_TMR1_ADDR) || (addr == GTG_PR1_ADDR) ||
                 (addr == GTG_T1_CTRL_ADDR) || (addr == GTG_TMR2_ADDR) ||
                 (addr == GTG_PR2_ADDR) || (addr == GTG_T2_CTRL_ADDR) ||
                 (addr == GTG_TMR3_ADDR) || (addr == GTG_T3_GATE_ADDR) ||
                 (addr == GTG_T3_CTRL_ADDR) || (addr == GTG_IRQ_EN_ADDR) ||
                 (addr == GTG_IRQ_CLR_ADDR);
  endfunction : gtg_mapped

  logic acc, wr, rd, t1_tick, t1_en, t1_in, t2_in, t2_tick, t2_match;
  logic t3_src, t3_in, t3_tick, gate_lvl, gate_ok, t3_ovf, t1_match;
  logic [3:0] t2_div;
  logic [7:0] ps1_tc, ps3_tc;

  always_comb begin
    acc = psel & penable;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    // timer one source
    if (!t1c_ff[GTG_T1_SRC_BIT]) begin
      t1_in = 1'b1;
    end else begin
      case (gtg_ecs_t'(t1c_ff[GTG_T1_ECS_LSB +: 2]))
        GTG_ECS_SECONDARY_OSC: t1_in = secondary_osc_tick;
        GTG_ECS_EXT: t1_in = ext_clock_tick;
        GTG_ECS_LOW_POWER_RC_OSC: t1_in = low_power_rc_osc_tick;
        default: t1_in = 1'b0; // reserved code gives no clock
      endcase
    end
    // gated accumulation only meaningful on the internal clock
    if (!t1c_ff[GTG_T1_SRC_BIT] && t1c_ff[GTG_T1_GATE_BIT]) begin
      t1_in = t1_in & gate_src[0];
    end
    // idle only stops the timer when software asked for it
    t1_en = t1c_ff[GTG_T1_RUN_BIT]
            & ~(t1c_ff[GTG_T1_IDLE_BIT] & device_idle);
    ps1_tc = gtg_div8(t1c_ff[GTG_T1_PS_LSB +: 2]);
    t1_tick = t1_en & t1_in & (ps1_ff == ps1_tc);
    t1_match = t1_tick & (tmr1_ff == pr1_ff);
    // timer two
    t2_in = t2c_ff[GTG_T2_RUN_BIT];
    // prescale codes 1x both give 16
    case (t2c_ff[1:0])
      2'b00: t2_div = 4'h0;
      2'b01: t2_div = 4'h3;
      default: t2_div = 4'hF;
    endcase
    t2_tick = t2_in & (ps2_ff == t2_div);
    t2_match = t2_tick & (tmr2_ff == pr2_ff);
    // timer three source
    case (t3c_ff[GTG_T3_CS_LSB +: 2])
      2'b00: t3_src = 1'b1;
      2'b01: t3_src = 1'b1;
      2'b10: t3_src = t3_ext_tick;
      default: t3_src = low_power_rc_osc_tick | secondary_osc_tick;
    endcase
    // gate pins are sampled each clock, so a gate pulse must last one cycle
    // selected gate level with polarity
    gate_lvl = gate_src[t3g_ff[1:0]] ~^ t3g_ff[GTG_G_POL_BIT];
    if (!t3g_ff[GTG_G_EN_BIT]) begin
      gate_ok = 1'b1;
    end else if (t3g_ff[GTG_G_SPM_BIT]) begin
      gate_ok = t3g_ff[GTG_G_GO_BIT] & t3g_ff[GTG_G_VAL_BIT];
    end else begin
      gate_ok = t3g_ff[GTG_G_VAL_BIT];
    end
    t3_in = t3c_ff[GTG_T3_RUN_BIT] & t3_src & gate_ok;
    // timer three prescale 1, 2, 4 or 8
    case (t3c_ff[GTG_T3_PS_LSB +: 2])
      2'b00: ps3_tc = 8'h00;
      2'b01: ps3_tc = 8'h01;
      2'b10: ps3_tc = 8'h03;
      default: ps3_tc = 8'h07;
    endcase
    t3_tick = t3_in & (ps3_ff >= ps3_tc);
    // a trigger in the wrap cycle clears the count, so no overflow flag
    t3_ovf = t3_tick & (tmr3_ff == 16'hFFFF) & ~special_event_trigger;
  end

  always_comb begin
    nxt_tmr1 = tmr1_ff;
    nxt_pr1 = pr1_ff;
    nxt_t1c = t1c_ff;
    nxt_tmr2 = tmr2_ff;
    nxt_pr2 = pr2_ff;
    nxt_t2c = t2c_ff;
    nxt_tmr3 = tmr3_ff;
    nxt_t3g = t3g_ff;
    nxt_t3c = t3c_ff;
    nxt_ps1 = ps1_ff;
    nxt_ps2 = ps2_ff;
    nxt_ps3 = ps3_ff;
    nxt_post2 = post2_ff;
    nxt_en = en_ff;
    nxt_sts = sts_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_t2o = 1'b0;
    // timer one counts up to its period
    if (t1_en & t1_in) begin
      nxt_ps1 = (ps1_ff == ps1_tc) ? 8'h00 : ps1_ff + 8'h01;
    end
    if (t1_tick) begin
      nxt_tmr1 = t1_match ? 16'h0000 : tmr1_ff + 16'h0001;
    end
    // timer two with postscaled match output
    if (t2_in) begin
      nxt_ps2 = (ps2_ff == t2_div) ? 4'h0 : ps2_ff + 4'h1;
    end
    // timer two is eight bits wide; its upper byte reads zero
    if (t2_tick) begin
      nxt_tmr2 = t2_match ? 16'h0000 : {8'h00, tmr2_ff[7:0] + 8'h01};
    end
    if (t2_match) begin
      if (post2_ff == t2c_ff[GTG_T2_POST_LSB +: 4]) begin
        nxt_post2 = 4'h0;
        nxt_t2o = 1'b1;
      end else begin
        nxt_post2 = post2_ff + 4'h1;
      end
    end
    // timer three
    if (t3_in) begin
      nxt_ps3 = t3_tick ? 8'h00 : ps3_ff + 8'h01;
    end
    if (special_event_trigger) begin
      nxt_tmr3 = 16'h0000;
    end else if (t3_tick) begin
      nxt_tmr3 = tmr3_ff + 16'h0001;
    end
    // gate edge tracking; toggle flips the value on each active edge
    nxt_gate_d = gate_lvl;
    if (t3g_ff[GTG_G_TOG_BIT]) begin
      if (gate_lvl & ~gate_d_ff) begin
        nxt_t3g[GTG_G_VAL_BIT] = ~t3g_ff[GTG_G_VAL_BIT];
      end
    end else begin
      nxt_t3g[GTG_G_VAL_BIT] = gate_lvl;
    end
    // one-shot done when the gate closes after an open pulse
    if (t3g_ff[GTG_G_SPM_BIT] & t3g_ff[GTG_G_GO_BIT] & t3g_ff[GTG_G_VAL_BIT] &
        ~nxt_t3g[GTG_G_VAL_BIT]) begin
      nxt_t3g[GTG_G_GO_BIT] = 1'b0;
      nxt_sts[GTG_IRQ_GATE] = 1'b1;
    end
    // register writes take effect in the access phase
    if (wr) begin
      if (paddr == GTG_TMR1_ADDR) begin
        nxt_tmr1 = pwdata[15:0];
      end else if (paddr == GTG_PR1_ADDR) begin
        nxt_pr1 = pwdata[15:0];
      end else if (paddr == GTG_T1_CTRL_ADDR) begin
        nxt_t1c = pwdata[15:0] & GTG_T1_MASK;
      end else if (paddr == GTG_TMR2_ADDR) begin
        nxt_tmr2 = {8'h00, pwdata[7:0]};
      end else if (paddr == GTG_PR2_ADDR) begin
        nxt_pr2 = {8'h00, pwdata[7:0]};
      end else if (paddr == GTG_T2_CTRL_ADDR) begin
        nxt_t2c = pwdata[15:0] & GTG_T2_MASK;
      end else if (paddr == GTG_TMR3_ADDR && !special_event_trigger) begin
        nxt_tmr3 = pwdata[15:0];
      end else if (paddr == GTG_T3_GATE_ADDR) begin
        nxt_t3g = (pwdata[15:0] & GTG_G_WMASK) | {13'h0000, nxt_t3g[2], 2'b00};
        nxt_t3g[1:0] = pwdata[1:0];
      end else if (paddr == GTG_T3_CTRL_ADDR) begin
        nxt_t3c = pwdata[15:0] & GTG_T3_MASK;
      end else if (paddr == GTG_IRQ_EN_ADDR) begin
        nxt_en = pwdata[3:0];
      end else if (paddr == GTG_IRQ_CLR_ADDR) begin
        nxt_sts = nxt_sts & ~pwdata[3:0];
      end
    end
    // timer one, two and three events set after the clear so a same-cycle one is kept
    if (t1_match) begin
      nxt_sts[GTG_IRQ_T1] = 1'b1;
    end
    if (t2_match && post2_ff == t2c_ff[GTG_T2_POST_LSB +: 4]) begin
      nxt_sts[GTG_IRQ_T2] = 1'b1;
    end
    if (t3_ovf) begin
      nxt_sts[GTG_IRQ_T3] = 1'b1;
    end
    // irq tracks the next status so it rises with the flag itself
    nxt_irq = |(nxt_sts & nxt_en);
    // zero-wait apb answer, pready high in the access phase cycle
    nxt_pready = psel & ~penable;
    if (psel & ~penable & ~pwrite) begin
      if (paddr == GTG_TMR1_ADDR) begin
        nxt_prdata = {16'h0000, tmr1_ff};
      end else if (paddr == GTG_PR1_ADDR) begin
        nxt_prdata = {16'h0000, pr1_ff};
      end else if (paddr == GTG_T1_CTRL_ADDR) begin
        nxt_prdata = {16'h0000, t1c_ff};
      end else if (paddr == GTG_TMR2_ADDR) begin
        nxt_prdata = {16'h0000, tmr2_ff};
      end else if (paddr == GTG_PR2_ADDR) begin
        nxt_prdata = {16'h0000, pr2_ff};
      end else if (paddr == GTG_T2_CTRL_ADDR) begin
        nxt_prdata = {16'h0000, t2c_ff};
      end else if (paddr == GTG_TMR3_ADDR) begin
        nxt_prdata = {16'h0000, tmr3_ff};
      end else if (paddr == GTG_T3_GATE_ADDR) begin
        nxt_prdata = {16'h0000, t3g_ff};
      end else if (paddr == GTG_T3_CTRL_ADDR) begin
        nxt_prdata = {16'h0000, t3c_ff};
      end else if (paddr == GTG_IRQ_STAT_ADDR) begin
        nxt_prdata = {28'h000_0000, sts_ff};
      end else if (paddr == GTG_IRQ_EN_ADDR) begin
        nxt_prdata = {28'h000_0000, en_ff};
      end else begin
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = ~(paddr == GTG_IRQ_CLR_ADDR);
      end
    end else if (psel & ~penable) begin
      nxt_prdata = 32'h0000_0000;
      nxt_pslverr = ~gtg_mapped(paddr);
    end
    // keep the answer steady for the whole access cycle
    if (rd) begin
      nxt_prdata = prdata_ff;
    end
  end

  // one register bank; every output below comes straight from it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr1_ff <= 16'h0000;
      pr1_ff <= GTG_PR1_RST;
      t1c_ff <= 16'h0000;
      tmr2_ff <= 16'h0000;
      pr2_ff <= GTG_PR2_RST;
      t2c_ff <= 16'h0000;
      tmr3_ff <= 16'h0000;
      t3g_ff <= 16'h0000;
      t3c_ff <= 16'h0000;
      ps1_ff <= 8'h00;
      ps2_ff <= 4'h0;
      ps3_ff <= 8'h00;
      post2_ff <= 4'h0;
      sts_ff <= 4'h0;
      en_ff <= 4'h0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      t2o_ff <= 1'b0;
      irq_ff <= 1'b0;
      gate_d_ff <= 1'b0;
    end else begin
      tmr1_ff <= nxt_tmr1;
      pr1_ff <= nxt_pr1;
      t1c_ff <= nxt_t1c;
      tmr2_ff <= nxt_tmr2;
      pr2_ff <= nxt_pr2;
      t2c_ff <= nxt_t2c;
      tmr3_ff <= nxt_tmr3;
      t3g_ff <= nxt_t3g;
      t3c_ff <= nxt_t3c;
      ps1_ff <= nxt_ps1;
      ps2_ff <= nxt_ps2;
      ps3_ff <= nxt_ps3;
      post2_ff <= nxt_post2;
      sts_ff <= nxt_sts;
      en_ff <= nxt_en;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      t2o_ff <= nxt_t2o;
      irq_ff <= nxt_irq;
      gate_d_ff <= nxt_gate_d;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign t2_match_out = t2o_ff;
  assign irq = irq_ff;
endmodule : gtg_timer_group

// ==== test/gtg_timer_group_asserts.sv ====
// port-level checks for the general timer group
`timescale 1ns/1ns
module gtg_timer_group_asserts
  import gtg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic special_event_trigger,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd_acc = pready && !pwrite;
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_only: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stands too long");
  a_err_unmapped: assert property (psel && penable && paddr[11:8] != 4'h1 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_t1_mask: assert property (rd_acc && paddr == GTG_T1_CTRL_ADDR |->
    (prdata[15:0] & ~GTG_T1_MASK) == 16'h0000) else $error("reserved control bit read");
  a_clear_reads: assert property (rd_acc && paddr == GTG_IRQ_CLR_ADDR |->
    prdata == 32'h0000_0000) else $error("clear register not zero");
  a_event_clear: assert property (special_event_trigger [*3] ##0
    (rd_acc && paddr == GTG_TMR3_ADDR) |-> prdata == 32'h0000_0000)
    else $error("count not held clear");
  a_irq_reset: assert property ($rose(presetn) |-> !irq)
    else $error("irq high after reset");
  c_refused: cover property (pslverr);
  c_irq: cover property (irq);
  c_event: cover property (special_event_trigger && pready);
endmodule : gtg_timer_group_asserts
bind gtg_timer_group gtg_timer_group_asserts u_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .special_event_trigger(special_event_trigger),
  .irq(irq));

// ==== test/gtg_timer_group_bench.sv ====
// self-checking bench for the general timer group
`timescale 1ns/1ns
module gtg_timer_group_bench;
  import gtg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, idle, sev, t2m, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, a;
  logic [3:0] gsrc;
  logic [4:0] tk;
  logic [4:0] msk [4] = '{5'h01, 5'h04, 5'h02, 5'h07};
  logic [31:0] t2c [4] = '{32'h0000_0004, 32'h0000_0005, 32'h0000_000E, 32'h0000_007C};
  int t2g [4] = '{4, 16, 128, 64};
  int dv [4] = '{1, 8, 64, 256};
  int errors, cmp_count, cyc, gap, since, np, n;
  gtg_timer_group DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .device_idle(idle), .secondary_osc_tick(tk[0]),
    .low_power_rc_osc_tick(tk[1]), .ext_clock_tick(tk[2]), .t3_ext_tick(tk[3]),
    .gate_src(gsrc), .special_event_trigger(sev), .t2_match_out(t2m), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // gap between match pulses; also the run ceiling
  always @(posedge pclk) begin
    cyc++;
    since++;
    if (t2m === 1'b1) begin
      gap = since;
      since = 0;
      np++;
    end
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
  endtask : wr
  task automatic rc(input logic [11:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0000_0000);
    chk($sformatf("reg %h", ad), rd, exp);
  endtask : rc
  task automatic moving(input logic e);
    xfer(1'b0, GTG_TMR1_ADDR, 32'h0000_0000);
    a = rd;
    xfer(1'b0, GTG_TMR1_ADDR, 32'h0000_0000);
    chk("timer one motion", {31'h0000_0000, rd != a}, {31'h0000_0000, e});
  endtask : moving
  task automatic ticks(input logic [4:0] m, input int cnt);
    repeat (cnt) begin
      @(posedge pclk);
      tk <= m;
      @(posedge pclk);
      tk <= 5'h00;
    end
  endtask : ticks
  // fresh reset per test so prescaler phase starts known
  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst
  initial begin
    {presetn, psel, penable, pwrite, idle, sev} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tk = 5'h00;
    gsrc = 4'h0;
    rst();
    rc(GTG_PR1_ADDR, 32'h0000_FFFF);
    rc(GTG_PR2_ADDR, 32'h0000_00FF);
    rc(GTG_TMR3_ADDR, 32'h0000_0000);
    xfer(1'b0, 12'h200, 32'h0000_0000);
    chk("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    wr(GTG_T1_CTRL_ADDR, 32'h0000_FFFF);
    rc(GTG_T1_CTRL_ADDR, {16'h0000, GTG_T1_MASK});
    wr(GTG_T2_CTRL_ADDR, 32'h0000_FFFF);
    rc(GTG_T2_CTRL_ADDR, {16'h0000, GTG_T2_MASK});
    $display("test registers done");
    rst();
    wr(GTG_T1_CTRL_ADDR, 32'h0000_8000);
    idle <= 1'b1;
    moving(1'b1);
    wr(GTG_T1_CTRL_ADDR, 32'h0000_A000);
    moving(1'b0);
    idle <= 1'b0;
    moving(1'b1);
    wr(GTG_T1_CTRL_ADDR, 32'h0000_0000);
    moving(1'b0);
    $display("test run and idle done");
    for (int i = 0; i < 4; i++) begin
      rst();
      wr(GTG_T1_CTRL_ADDR, 32'h0000_8002 | (i << 8));
      ticks(msk[i], 5);
      ticks(msk[i] ^ 5'h07, 3);
      rc(GTG_TMR1_ADDR, (i == 3) ? 32'h0000_0000 : 32'h0000_0005);
    end
    for (int i = 1; i < 4; i++) begin
      rst();
      wr(GTG_T1_CTRL_ADDR, 32'h0000_8002 | (i << 4));
      ticks(5'h01, 2 * dv[i]);
      rc(GTG_TMR1_ADDR, 32'h0000_0002);
    end
    $display("test clock select and prescale done");
    rst();
    wr(GTG_TMR3_ADDR, 32'h0000_1234);
    rc(GTG_TMR3_ADDR, 32'h0000_1234);
    wr(GTG_T3_CTRL_ADDR, 32'h0000_0081);
    ticks(5'h08, 3);
    rc(GTG_TMR3_ADDR, 32'h0000_1237);
    sev <= 1'b1;
    wr(GTG_TMR3_ADDR, 32'h0000_5555);
    rc(GTG_TMR3_ADDR, 32'h0000_0000);
    sev <= 1'b0;
    wr(GTG_T3_GATE_ADDR, 32'h0000_00C0);
    ticks(5'h08, 3);
    rc(GTG_TMR3_ADDR, 32'h0000_0000);
    gsrc <= 4'h1;
    ticks(5'h08, 2);
    rc(GTG_TMR3_ADDR, 32'h0000_0002);
    $display("test timer three done");
    rst();
    wr(GTG_IRQ_EN_ADDR, 32'h0000_0004);
    wr(GTG_TMR3_ADDR, 32'h0000_FFFE);
    wr(GTG_T3_CTRL_ADDR, 32'h0000_0001);
    wr(GTG_T3_CTRL_ADDR, 32'h0000_0000);
    rc(GTG_IRQ_STAT_ADDR, 32'h0000_0004);
    chk("irq raised", {31'h0000_0000, irq}, 32'h0000_0001);
    wr(GTG_IRQ_EN_ADDR, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
    wr(GTG_IRQ_EN_ADDR, 32'h0000_0004);
    wr(GTG_IRQ_CLR_ADDR, 32'h0000_0004);
    wr(GTG_IRQ_STAT_ADDR, 32'h0000_0004);
    repeat (3) @(posedge pclk);
    chk("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
    rc(GTG_IRQ_STAT_ADDR, 32'h0000_0000);
    $display("test interrupt done");
    // one-shot: polarity first so the gate value is settled before arming
    rst();
    gsrc <= 4'h0;
    wr(GTG_T3_GATE_ADDR, 32'h0000_0040);
    wr(GTG_T3_GATE_ADDR, 32'h0000_00D8);
    wr(GTG_T3_CTRL_ADDR, 32'h0000_0001);
    gsrc <= 4'h1;
    repeat (5) @(posedge pclk);
    gsrc <= 4'h0;
    repeat (3) @(posedge pclk);
    gsrc <= 4'h1;
    repeat (3) @(posedge pclk);
    rc(GTG_TMR3_ADDR, 32'h0000_0005);
    rc(GTG_T3_GATE_ADDR, 32'h0000_00D4);
    rc(GTG_IRQ_STAT_ADDR, 32'h0000_0008);
    // toggle: first gate edge opens, second closes
    rst();
    gsrc <= 4'h0;
    wr(GTG_T3_GATE_ADDR, 32'h0000_0040);
    wr(GTG_T3_GATE_ADDR, 32'h0000_00E0);
    wr(GTG_T3_CTRL_ADDR, 32'h0000_0001);
    repeat (2) begin
      gsrc <= 4'h1;
      repeat (2) @(posedge pclk);
      gsrc <= 4'h0;
      repeat (4) @(posedge pclk);
    end
    rc(GTG_TMR3_ADDR, 32'h0000_0006);
    $display("test gate modes done");
    rst();
    wr(GTG_PR2_ADDR, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      wr(GTG_T2_CTRL_ADDR, t2c[i]);
      repeat (400) @(posedge pclk);
      chk("timer two gap", gap, t2g[i]);
    end
    wr(GTG_T2_CTRL_ADDR, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    n = np;
    repeat (300) @(posedge pclk);
    chk("timer two halted", np, n);
    rc(GTG_IRQ_STAT_ADDR, 32'h0000_0002);
    $display("test timer two done");
    test_done();
  end
endmodule : gtg_timer_group_bench
